// ### rtl/twu_top.sv
// Timer watchdog unit with classic Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module twu_top
	import twu_pkg::*;
(
	input  wire logic        sys_clk,       // System clock, 100 MHz
	input  wire logic        rst,           // Async reset, active high
	input  wire logic        wb_cyc_i,      // Wishbone cycle
	input  wire logic        wb_stb_i,      // Wishbone strobe
	input  wire logic        wb_we_i,       // Wishbone write enable
	input  wire logic [11:0] wb_adr_i,      // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,      // Wishbone byte selects
	input  wire logic [31:0] wb_dat_i,      // Wishbone write data
	output logic      [31:0] wb_dat_o,      // Wishbone read data
	output logic             wb_ack_o,      // Wishbone acknowledge
	output logic             wb_err_o,      // Wishbone error, unmapped
	input  wire logic        timer_in_pin,  // External timer input
	output logic             timer_output_pin, // Timer output pin
	output logic             timer_irq,     // End-of-count request pulse
	output logic             top_level_sel, // Top level interrupt select
	output logic             a0_chan_sel,   // Interrupt A0 channel select
	output logic             wdog_reset     // System reset request pulse
);
	logic [7:0]     counter_load_high_byte_reg;
	logic [7:0]     counter_load_low_byte_reg;
	logic [7:0]     prescale_divider_reg;
	logic [7:0]     timer_control_register_reg;
	logic [7:0]     shared_wait_control_register_reg;
	logic [7:0]     external_vector_register_reg;
	logic [15:0]    count_reg;
	logic [1:0]     fix_div_reg;
	logic [7:0]     presc_cnt_reg;
	logic           armed_reg;
	logic           running_reg;
	logic           eoc_flag_reg;
	logic           out_reg;
	logic           key_seen_reg;
	logic           wb_ack_reg;
	logic [31:0]    rd_data_reg;
	logic           in_level;
	logic           in_fall;
	logic           run_control_bit;
	logic           output_enable_bit;
	logic           output_mode_select;
	logic           pwm_output_level;
	logic           wdog_en;
	twu_inmode_type in_mode;
	logic           req;
	logic           wr_go;
	logic           hit;
	logic [9:0]     word_idx;
	logic           count_en;
	logic           presc_tick;
	logic           tick;
	logic           eoc;
	logic           reload_now;
	logic           low_wr;
	logic           eoc_clr;
	logic           wdog_serv;

	twu_pin_sync u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_in  (timer_in_pin),
		.level   (in_level),
		.fall    (in_fall)
	);

	// Control field decode
	// mode from control
	assign in_mode            = twu_inmode_type'(timer_control_register_reg[TWU_CTL_INHI:TWU_CTL_INLO]);
	assign run_control_bit    = timer_control_register_reg[TWU_CTL_RUN];
	assign output_enable_bit  = timer_control_register_reg[TWU_CTL_OUTPUT_ENABLE_BIT];
	assign output_mode_select = timer_control_register_reg[TWU_CTL_OUTPUT_MODE_SELECT];
	assign pwm_output_level   = timer_control_register_reg[TWU_CTL_PWMLVL];
	assign wdog_en            = shared_wait_control_register_reg[TWU_WCR_WDOG];
	assign top_level_sel      = external_vector_register_reg[TWU_EIV_TOPSEL];
	assign a0_chan_sel        = external_vector_register_reg[TWU_EIV_A0SEL];

	// Bus decode: word index is the printed offset
	assign req      = wb_cyc_i && wb_stb_i && !wb_ack_reg && !wb_err_o;
	assign word_idx = wb_adr_i[11:2];
	assign hit      = (word_idx >= TWU_IDX_HIGH) && (word_idx <= TWU_IDX_COUNT_L);
	assign wr_go    = req && wb_we_i && wb_sel_i[0] && hit;
	assign low_wr   = wr_go && (word_idx == TWU_IDX_LOW);
	assign eoc_clr  = wr_go && (word_idx == TWU_IDX_STATUS) && wb_dat_i[TWU_ST_EOC];

	// One-cycle answer; ack and err drop in the following cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_ack_reg <= 1'b0;
			wb_err_o   <= 1'b0;
		end else begin
			wb_ack_reg <= req && hit;
			wb_err_o   <= req && !hit;
		end
	end
	assign wb_ack_o = wb_ack_reg;
	assign wb_dat_o = rd_data_reg;

	// Read mux sampled on the request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (req) begin
			unique case (word_idx)
				TWU_IDX_HIGH:    rd_data_reg <= {24'h00_0000, counter_load_high_byte_reg};
				TWU_IDX_LOW:     rd_data_reg <= {24'h00_0000, counter_load_low_byte_reg};
				TWU_IDX_PRESC:   rd_data_reg <= {24'h00_0000, prescale_divider_reg};
				TWU_IDX_CTRL:    rd_data_reg <= {24'h00_0000, timer_control_register_reg};
				TWU_IDX_WAITCR:  rd_data_reg <= {24'h00_0000, shared_wait_control_register_reg};
				TWU_IDX_EXTVEC:  rd_data_reg <= {24'h00_0000, external_vector_register_reg};
				TWU_IDX_STATUS:  rd_data_reg <= {29'h0000_0000, out_reg, running_reg, eoc_flag_reg};
				TWU_IDX_COUNT_H: rd_data_reg <= {24'h00_0000, count_reg[15:8]};
				TWU_IDX_COUNT_L: rd_data_reg <= {24'h00_0000, count_reg[7:0]};
				default:         rd_data_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Load and prescaler registers, writable while counting
	// on-the-fly load
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			counter_load_high_byte_reg <= TWU_RST_LOAD;
			counter_load_low_byte_reg  <= TWU_RST_LOAD;
			prescale_divider_reg       <= TWU_RST_PRESC;
		end else if (wr_go) begin
			if (word_idx == TWU_IDX_HIGH) begin
				counter_load_high_byte_reg <= wb_dat_i[7:0];
			end
			if (word_idx == TWU_IDX_LOW) begin
				counter_load_low_byte_reg <= wb_dat_i[7:0];
			end
			if (word_idx == TWU_IDX_PRESC) begin
				prescale_divider_reg <= wb_dat_i[7:0];
			end
		end
	end

	// Control registers; watchdog enable is sticky until reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_control_register_reg       <= TWU_RST_ZERO;
			shared_wait_control_register_reg <= TWU_RST_ZERO;
			external_vector_register_reg     <= TWU_RST_ZERO;
		end else if (wr_go) begin
			if (word_idx == TWU_IDX_CTRL) begin
				timer_control_register_reg <= wb_dat_i[7:0];
			end
			if (word_idx == TWU_IDX_WAITCR) begin
				shared_wait_control_register_reg <= wb_dat_i[7:0]
					| (shared_wait_control_register_reg & (8'h0001 << TWU_WCR_WDOG));
			end
			if (word_idx == TWU_IDX_EXTVEC) begin
				external_vector_register_reg <= wb_dat_i[7:0];
			end
		end
	end

	// Triggerable arm/start tracking
	// arm then edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			armed_reg   <= 1'b0;
			running_reg <= 1'b0;
		end else if (!run_control_bit) begin
			armed_reg   <= 1'b0;
			running_reg <= 1'b0;
		end else if (in_mode == TWU_IN_TRIG) begin
			armed_reg   <= 1'b1;
			running_reg <= running_reg || (armed_reg && in_fall);
		end else begin
			armed_reg   <= 1'b1;
			running_reg <= 1'b1;
		end
	end

	// Counting permission per input mode; watchdog always counts
	always_comb begin
		count_en = 1'b0;
		if (wdog_en) begin
			count_en = 1'b1;
		end else if (run_control_bit) begin
			unique case (in_mode)
				TWU_IN_GATED:  count_en = in_level;
				TWU_IN_TRIG:   count_en = running_reg;
				TWU_IN_RETRIG: count_en = 1'b1;
				TWU_IN_FREE:   count_en = 1'b1;
			endcase
		end
	end

	// Fixed divide by four of the system clock
	// clock over four
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fix_div_reg <= 2'b00;
		end else if (count_en) begin
			fix_div_reg <= fix_div_reg + 2'b01;
		end
	end

	// Programmable prescaler, value plus one
	// divide by N+1
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			presc_cnt_reg <= TWU_RST_ZERO;
		end else if (count_en && fix_div_reg == TWU_FIX_LAST) begin
			if (presc_cnt_reg >= prescale_divider_reg) begin
				presc_cnt_reg <= TWU_RST_ZERO;
			end else begin
				presc_cnt_reg <= presc_cnt_reg + 8'h0001;
			end
		end
	end
	assign presc_tick = presc_cnt_reg >= prescale_divider_reg;
	assign tick       = count_en && (fix_div_reg == TWU_FIX_LAST) && presc_tick;
	assign eoc        = tick && (count_reg == 16'h0000);

	assign reload_now = (!wdog_en) && run_control_bit && (in_mode == TWU_IN_RETRIG) && in_fall;

	// Main down counter
	// decrement and reload
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_reg <= 16'hFFFF;
		end else if (reload_now || eoc || wdog_serv) begin
			count_reg <= {counter_load_high_byte_reg, counter_load_low_byte_reg};
		end else if (tick) begin
			count_reg <= count_reg - 16'h0001;
		end
	end

	// End-of-count status flag; a new end of count beats the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eoc_flag_reg <= 1'b0;
		end else if (eoc) begin
			eoc_flag_reg <= 1'b1;
		end else if (eoc_clr) begin
			eoc_flag_reg <= 1'b0;
		end
	end

	// Interrupt request pulse
	// end-of-count request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= eoc;
		end
	end

	// Output waveform state, updated at end of count and forced high while the output is disabled
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			out_reg <= 1'b1;
		end else if (!output_enable_bit) begin
			out_reg <= 1'b1;
		end else if (eoc) begin
			out_reg <= output_mode_select ? pwm_output_level : !out_reg;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_output_pin <= 1'b1;
		end else begin
			timer_output_pin <= output_enable_bit ? out_reg : 1'b1;
		end
	end

	// Watchdog service: first key then second key written to low byte
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			key_seen_reg <= 1'b0;
		end else if (low_wr) begin
			key_seen_reg <= (wb_dat_i[7:0] == TWU_WDOG_KEY1);
		end
	end
	// key pair restarts count; keys also land in the low load byte
	assign wdog_serv = wdog_en && key_seen_reg && low_wr && (wb_dat_i[7:0] == TWU_WDOG_KEY2);

	// watchdog reset
	// Service reloads the counter; expiry pulses the reset request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdog_reset <= 1'b0;
		end else begin
			wdog_reset <= wdog_en && eoc;
		end
	end

	// Assertions
	AST_GATE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		(!wdog_en && run_control_bit && in_mode == TWU_IN_GATED && !in_level)
		|=> $stable(count_reg))
		else $error("Counter moved with gate low");
	AST_TRIG_NOSTART: assert property (@(posedge sys_clk) disable iff (rst)
		(!wdog_en && in_mode == TWU_IN_TRIG && !running_reg && !in_fall)
		|=> $stable(count_reg) || $past(reload_now))
		else $error("Triggerable mode counted before start");
	AST_TRIG_STOP: assert property (@(posedge sys_clk) disable iff (rst)
		!run_control_bit |=> !running_reg)
		else $error("Still running after run bit clear");
	AST_RETRIG_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
		reload_now |=> count_reg == $past({counter_load_high_byte_reg, counter_load_low_byte_reg}))
		else $error("Retrigger did not reload");
	AST_RETRIG_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
		(!run_control_bit && !wdog_en && in_mode == TWU_IN_RETRIG && in_fall) |=> $stable(count_reg))
		else $error("Edge acted while stopped");
	AST_OUT_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		!output_enable_bit |=> timer_output_pin)
		else $error("Disabled output not high");
	sequence sq_toggle_seq;
		(eoc && output_enable_bit && !output_mode_select) ##1 output_enable_bit;
	endsequence
	AST_SQUARE: assert property (@(posedge sys_clk) disable iff (rst)
		sq_toggle_seq |-> out_reg != $past(out_reg))
		else $error("Square wave did not toggle");
	AST_PWM: assert property (@(posedge sys_clk) disable iff (rst)
		(eoc && output_enable_bit && output_mode_select)
		|=> out_reg == $past(pwm_output_level) || !output_enable_bit)
		else $error("Pulse level not copied");
	AST_WDOG: assert property (@(posedge sys_clk) disable iff (rst)
		(wdog_en && eoc) |=> wdog_reset)
		else $error("Watchdog expiry without reset");
	AST_WDOG_SERVE: assert property (@(posedge sys_clk) disable iff (rst)
		wdog_serv |=> count_reg == $past({counter_load_high_byte_reg, counter_load_low_byte_reg}))
		else $error("Watchdog service did not restart count");
	AST_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
		eoc |=> timer_irq ##1 !timer_irq || eoc)
		else $error("End-of-count request missing");
endmodule // twu_top
`default_nettype wire

// ### rtl/twu_pkg.sv
// Shared constants for the timer watchdog unit
package twu_pkg;
	// Register word indices; the byte address is four times the index
	localparam logic [9:0] TWU_IDX_HIGH    = 10'h0F8;
	localparam logic [9:0] TWU_IDX_LOW     = 10'h0F9;
	localparam logic [9:0] TWU_IDX_PRESC   = 10'h0FA;
	localparam logic [9:0] TWU_IDX_CTRL    = 10'h0FB;
	localparam logic [9:0] TWU_IDX_WAITCR  = 10'h0FC;
	localparam logic [9:0] TWU_IDX_EXTVEC  = 10'h0FD;
	localparam logic [9:0] TWU_IDX_STATUS  = 10'h0FE;
	localparam logic [9:0] TWU_IDX_COUNT_H = 10'h0FF;
	localparam logic [9:0] TWU_IDX_COUNT_L = 10'h100;
	// Reset values
	localparam logic [7:0] TWU_RST_LOAD    = 8'h00FF;
	localparam logic [7:0] TWU_RST_PRESC   = 8'h00FF;
	localparam logic [7:0] TWU_RST_ZERO    = 8'h0000;
	// Control register fields
	localparam int TWU_CTL_RUN    = 0;
	localparam int TWU_CTL_INLO   = 1;
	localparam int TWU_CTL_INHI   = 2;
	localparam int TWU_CTL_OUTPUT_ENABLE_BIT  = 3;
	localparam int TWU_CTL_OUTPUT_MODE_SELECT  = 4;
	localparam int TWU_CTL_PWMLVL = 5;
	localparam int TWU_CTL_EXTCLK = 6;
	// Shared wait control and vector fields
	localparam int TWU_WCR_WDOG   = 6;
	localparam int TWU_EIV_TOPSEL = 2;
	localparam int TWU_EIV_A0SEL  = 1;
	// Status fields
	localparam int TWU_ST_EOC     = 0;
	localparam int TWU_ST_RUNNING = 1;
	localparam int TWU_ST_OUT     = 2;
	// Watchdog service sequence written to the low byte
	localparam logic [7:0] TWU_WDOG_KEY1 = 8'h00AA;
	localparam logic [7:0] TWU_WDOG_KEY2 = 8'h0055;
	// Fixed internal divider before the programmable prescaler
	localparam int TWU_FIX_DIV = 4;
	localparam logic [1:0] TWU_FIX_LAST = 2'(TWU_FIX_DIV - 1);
	// Input modes
	typedef enum logic [1:0] {
		TWU_IN_FREE,
		TWU_IN_GATED,
		TWU_IN_TRIG,
		TWU_IN_RETRIG
	} twu_inmode_type;
endpackage : twu_pkg

// ### rtl/twu_pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module twu_pin_sync
	import twu_pkg::*;
(
	input  wire logic sys_clk,   // System clock
	input  wire logic rst,       // Async reset, active high
	input  wire logic pin_in,    // Raw pin
	output logic      level,     // Filtered level
	output logic      fall       // One-cycle high-to-low pulse
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// First stage feeds only the second
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level <= 1'b1;
		end else if (s2_reg == s3_reg) begin
			level <= s3_reg;
		end
	end

	assign fall = level && (s2_reg == s3_reg) && !s3_reg;
endmodule // twu_pin_sync
`default_nettype wire

// ### testbench/twu_pin_model.sv
// Behavioural source that drives the timer input pin
`timescale 1ns/10ps
`default_nettype none
module twu_pin_model (
	input  wire logic sys_clk,  // System clock
	input  wire logic rst,      // Async reset, active high
	input  wire logic want_lvl, // Level the bench asks for
	output logic      pin       // Timer input pin, idle high
);
	logic [2:0] hold_reg; // Clocks left before the next change

	// slow gate toggling
	// Each level stands eight clocks, so toggles never pass clock/8
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin      <= 1'b1;
			hold_reg <= 3'h0;
		end else if (hold_reg != 3'h0) begin
			hold_reg <= hold_reg - 3'h1;
		end else if (pin != want_lvl) begin
			pin      <= want_lvl;
			hold_reg <= 3'h7;
		end
	end
endmodule // twu_pin_model
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the timer watchdog unit
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import twu_pkg::*;
;
	typedef struct packed {logic err; logic chk; logic [31:0] dat;} twu_note_type;
	logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, want_lvl;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        wb_ack_o, wb_err_o, timer_in_pin, timer_output_pin;
	logic        timer_irq, top_level_sel, a0_chan_sel, wdog_reset;
	int          fails, n_checks, n;
	logic        s, p;
	logic [7:0]  r;
	logic [7:0]  pv[3] = '{8'h00, 8'h02, 8'hFF};
	logic [7:0]  lv[3] = '{8'h28, 8'h28, 8'h00};
	twu_note_type notes[$];
	twu_note_type cur;

	twu_top dut_u (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .timer_in_pin,
		.timer_output_pin, .timer_irq, .top_level_sel, .a0_chan_sel, .wdog_reset);
	twu_pin_model pin_u (.sys_clk, .rst, .want_lvl, .pin(timer_in_pin));

	// Free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic trip();
		fails++;
		$display("[ERR] %0t wait ran out", $time);
		end_sim();
	endtask

	// One classic cycle; the answer is matched by the monitor below
	task automatic bus(input logic [9:0] idx, input logic w, input logic [3:0] sel,
		input logic [7:0] d, input twu_note_type nt);
		int k;
		notes.push_back(nt);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_sel_i <= sel;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h00_0000, d};
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 50);
		if (k >= 50) trip();
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, 4'hF, d, '0);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [7:0] e);
		bus(idx, 1'b0, 4'hF, 8'h00, {2'b01, 24'h00_0000, e});
	endtask

	task automatic wait_irq(input int lim, output int c);
		c = 0;
		do begin
			@(posedge sys_clk);
			c++;
		end while (timer_irq !== 1'b1 && c < lim);
		if (timer_irq !== 1'b1) trip();
	endtask

	task automatic quiet(input int c, output logic seen);
		seen = 1'b0;
		repeat (c) begin
			@(posedge sys_clk);
			if (timer_irq === 1'b1) seen = 1'b1;
		end
	endtask

	// Falling then rising edge, each level held 20 clocks
	task automatic pulse();
		want_lvl <= 1'b0;
		repeat (20) @(posedge sys_clk);
		want_lvl <= 1'b1;
		repeat (20) @(posedge sys_clk);
	endtask

	// Oldest note is compared with each bus answer
	always @(posedge sys_clk) begin
		if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
			cur = notes.pop_front();
			check({31'h0, wb_err_o}, {31'h0, cur.err});
			if (cur.chk) check(wb_dat_o, cur.dat);
		end
	end

	initial begin
		{rst, want_lvl} = 2'b11;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		fails = 0;
		n_checks = 0;
		void'($urandom(36));
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(TWU_IDX_HIGH, TWU_RST_LOAD);
		rd(TWU_IDX_LOW, TWU_RST_LOAD);
		rd(TWU_IDX_PRESC, TWU_RST_PRESC);
		check({31'h0, timer_output_pin}, 32'h1);
		r = 8'($urandom());
		wr(TWU_IDX_HIGH, r);
		bus(TWU_IDX_HIGH, 1'b1, 4'hE, ~r, '0); // Lane 0 off, so no effect
		wr(TWU_IDX_LOW, ~r);
		rd(TWU_IDX_HIGH, r);
		rd(TWU_IDX_LOW, ~r);
		bus(10'h010, 1'b0, 4'hF, 8'h00, {2'b10, 32'h0000_0000}); // Unmapped
		$display("bus test done");
		foreach (pv[i]) begin
			wr(TWU_IDX_LOW, lv[i]);
			wr(TWU_IDX_HIGH, 8'h00);
			wr(TWU_IDX_PRESC, pv[i]);
			// Retrigger once so the count starts from the new load value
			wr(TWU_IDX_CTRL, 8'h07);
			pulse();
			wr(TWU_IDX_CTRL, 8'h03);
			wait_irq(3000, n);
			wait_irq(3000, n);
			check(n, 4 * (pv[i] + 1) * (lv[i] + 1));
			wr(TWU_IDX_CTRL, 8'h00);
		end
		wr(TWU_IDX_LOW, 8'h28);
		wr(TWU_IDX_PRESC, 8'h00);
		wr(TWU_IDX_CTRL, 8'h03);
		want_lvl <= 1'b0;
		quiet(20, s);
		quiet(400, s);
		check({31'h0, s}, 32'h0);
		want_lvl <= 1'b1;
		wait_irq(400, n);
		$display("gated test done");
		wr(TWU_IDX_CTRL, 8'h0B);
		wait_irq(400, n);
		repeat (3) @(posedge sys_clk);
		p = timer_output_pin;
		wait_irq(400, n);
		repeat (3) @(posedge sys_clk);
		check({31'h0, timer_output_pin}, {31'h0, ~p});
		wr(TWU_IDX_CTRL, 8'h3B);
		wait_irq(400, n);
		repeat (3) @(posedge sys_clk);
		check({31'h0, timer_output_pin}, 32'h1);
		wr(TWU_IDX_CTRL, 8'h1B);
		check({31'h0, timer_output_pin}, 32'h1);
		wait_irq(400, n);
		repeat (3) @(posedge sys_clk);
		check({31'h0, timer_output_pin}, 32'h0);
		wr(TWU_IDX_CTRL, 8'h13);
		check({31'h0, timer_output_pin}, 32'h1);
		$display("output test done");
		wr(TWU_IDX_CTRL, 8'h04);
		pulse();
		wr(TWU_IDX_CTRL, 8'h05);
		quiet(400, s);
		check({31'h0, s}, 32'h0);
		pulse();
		wait_irq(400, n);
		pulse();
		wait_irq(400, n);
		wr(TWU_IDX_CTRL, 8'h04);
		quiet(20, s);
		quiet(400, s);
		check({31'h0, s}, 32'h0);
		wr(TWU_IDX_CTRL, 8'h06);
		pulse();
		quiet(400, s);
		check({31'h0, s}, 32'h0);
		wr(TWU_IDX_CTRL, 8'h07);
		wait_irq(400, n);
		fork
			repeat (6) pulse();
			quiet(240, s);
		join
		check({31'h0, s}, 32'h0);
		wait_irq(400, n);
		check({31'h0, n > 100}, 32'h1);
		$display("input mode test done");
		wr(TWU_IDX_EXTVEC, 8'h06);
		check({30'h0, top_level_sel, a0_chan_sel}, 32'h3);
		wr(TWU_IDX_EXTVEC, 8'h02);
		check({30'h0, top_level_sel, a0_chan_sel}, 32'h1);
		wr(TWU_IDX_CTRL, 8'h00);
		wr(TWU_IDX_WAITCR, 8'h40);
		wr(TWU_IDX_LOW, TWU_WDOG_KEY1);
		wr(TWU_IDX_LOW, TWU_WDOG_KEY2);
		s = 1'b0;
		repeat (4) begin
			repeat (80) begin
				@(posedge sys_clk);
				if (wdog_reset === 1'b1) s = 1'b1;
			end
			wr(TWU_IDX_LOW, TWU_WDOG_KEY1);
			wr(TWU_IDX_LOW, TWU_WDOG_KEY2);
		end
		check({31'h0, s}, 32'h0);
		n = 0;
		while (wdog_reset !== 1'b1 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		check({31'h0, wdog_reset}, 32'h1);
		$display("watchdog test done");
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
